/* src/trs_pkg.sv */
// Constants shared by the thermal reading register set.
// Assumes a single 100 MHz clock domain.
package trs_pkg;
    localparam int          DATA_W        = 8;
    localparam int          FRAC_W        = 4;
    localparam logic [7:0]  CMD_READING   = 8'h00;
    localparam logic [7:0]  CMD_SETTINGS  = 8'h01;
    localparam logic [7:0]  READING_RST   = 8'h00;
    localparam logic [7:0]  SETTINGS_RST  = 8'h00;
    localparam logic [7:0]  CODE_MAX      = 8'h7F;
    localparam logic [7:0]  CODE_MIN      = 8'h80;
    localparam int          BIT_LOWPOWER  = 7;
    localparam int          BIT_READY     = 6;
    localparam logic [7:0]  SETTINGS_WMSK = 8'h80;
    localparam logic [6:0]  DEV_ADDR      = 7'h00; // Arbitrary default
    localparam logic [2:0]  BIT_LAST      = 3'h7;
    localparam logic [2:0]  BIT_FIRST     = 3'h0;
    localparam int          SYNC_W        = 2;
endpackage : trs_pkg

/* src/trs_code_former.sv */
// Forms the 8-bit reading code from a signed fixed-point temperature.
// Assumes the input is stable whenever resultValid is high.
`timescale 1ns/10ps
module trs_code_former #(
    parameter int TEMP_W = 12,
    parameter int FRAC_W = trs_pkg::FRAC_W
) (
    input  wire logic [TEMP_W-1:0] tempFixed,
    output logic      [7:0]        readingCode
);
    logic signed [TEMP_W-FRAC_W-1:0] wholeDeg;

    always_comb begin
        // Arithmetic shift floors toward negative infinity
        wholeDeg = $signed(tempFixed[TEMP_W-1:FRAC_W]);
        if (int'(wholeDeg) > int'($signed(trs_pkg::CODE_MAX))) begin
            readingCode = trs_pkg::CODE_MAX;
        end else if (int'(wholeDeg) < int'($signed(trs_pkg::CODE_MIN))) begin
            readingCode = trs_pkg::CODE_MIN;
        end else begin
            readingCode = wholeDeg[7:0];
        end
    end
endmodule : trs_code_former

/* src/trs_register_set.sv */
// Reading and settings registers of a serial temperature sensor, with
// a byte-wide write port and a bit-serial read port toward the two-wire bus engine.
// Assumes the bus engine and converter run on the same clock.
`timescale 1ns/10ps
module trs_register_set #(
    parameter int TEMP_W = 12
) (
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic [TEMP_W-1:0] tempFixed,
    input  wire logic              resultValid,
    input  wire logic              cmdWrite,
    input  wire logic [7:0]        cmdByte,
    input  wire logic              dataWrite,
    input  wire logic [7:0]        dataByte,
    input  wire logic              loadShift,
    input  wire logic              shiftStep,
    output logic                   txBit,
    output logic      [7:0]        readingOut,
    output logic                   lowPowerRequest,
    output logic                   conversionReady
);
    localparam int SYNC_W = trs_pkg::SYNC_W;

    // Reading register and ready flag
    logic [7:0]        reading_reg;
    logic [7:0]        reading_next;
    logic              ready_reg;
    logic              ready_next;

    // Settings and latched command
    logic [7:0]        settings_reg;
    logic [7:0]        settings_next;
    logic [7:0]        command_reg;
    logic [7:0]        command_next;

    // Transmit shifter
    logic [7:0]        shift_reg;
    logic [7:0]        shift_next;
    logic              txBit_reg;
    logic              txBit_next;

    // Valid synchroniser and rising-edge detector
    logic [SYNC_W-1:0] validSync_reg;
    logic [SYNC_W-1:0] validSync_next;
    logic              validPrev_reg;
    logic              validPrev_next;

    // Next values of the output copies
    logic [7:0]        readingOut_next;
    logic              lowPower_next;
    logic              readyOut_next;

    logic [7:0]        formedCode;
    logic              validRise;
    logic              lowPowerHeld;
    logic [7:0]        selected;

    trs_code_former #(
        .TEMP_W      (TEMP_W)
    ) i_trs_code_former (
        .tempFixed   (tempFixed),
        .readingCode (formedCode)
    );

    function automatic logic [7:0] readSelect(input logic [7:0] cmd,
                                              input logic [7:0] rd,
                                              input logic [7:0] st);
        if (cmd == trs_pkg::CMD_READING) begin
            readSelect = rd;
        end else if (cmd == trs_pkg::CMD_SETTINGS) begin
            readSelect = st;
        end else begin
            readSelect = 8'h00;
        end
    endfunction : readSelect

    // Synchroniser group
    always_comb begin
        validSync_next = {validSync_reg[SYNC_W-2:0], resultValid};
        validPrev_next = validSync_reg[SYNC_W-1];
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            validSync_reg <= '0;
            validPrev_reg <= 1'b0;
        end else begin
            validSync_reg <= validSync_next;
            validPrev_reg <= validPrev_next;
        end
    end

    // Only the last stage feeds logic; the first may be metastable
    assign validRise    = validSync_reg[SYNC_W-1] & ~validPrev_reg;
    assign lowPowerHeld = settings_reg[trs_pkg::BIT_LOWPOWER];

    // Reading group: low power blocks loads and wins over a set
    always_comb begin
        ready_next   = ready_reg;
        reading_next = reading_reg;
        if (lowPowerHeld) begin
            ready_next = 1'b0;
        end else if (validRise) begin
            ready_next   = 1'b1;
            reading_next = formedCode;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reading_reg <= trs_pkg::READING_RST;
            ready_reg   <= 1'b0;
        end else begin
            reading_reg <= reading_next;
            ready_reg   <= ready_next;
        end
    end

    // Settings group
    always_comb begin
        command_next  = command_reg;
        settings_next = settings_reg;
        if (cmdWrite) begin
            command_next = cmdByte;
        end
        // Writes to the reading command are dropped
        if (dataWrite && command_reg == trs_pkg::CMD_SETTINGS) begin
            settings_next = dataByte & trs_pkg::SETTINGS_WMSK;
        end
        settings_next[trs_pkg::BIT_READY] = ready_reg;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            settings_reg <= trs_pkg::SETTINGS_RST;
            command_reg  <= trs_pkg::CMD_READING;
        end else begin
            settings_reg <= settings_next;
            command_reg  <= command_next;
        end
    end

    // Transmit group: one byte per load, most significant bit first
    assign selected = readSelect(command_reg, reading_reg,
                                 settings_reg);

    always_comb begin
        shift_next = shift_reg;
        txBit_next = txBit_reg;
        if (loadShift) begin
            shift_next = selected;
            txBit_next = selected[trs_pkg::BIT_LAST];
        end else if (shiftStep) begin
            shift_next = {shift_reg[6:0], 1'b0};
            txBit_next = shift_reg[6];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= 8'h00;
            txBit_reg <= 1'b0;
        end else begin
            shift_reg <= shift_next;
            txBit_reg <= txBit_next;
        end
    end

    // Output group: every port comes straight from a flop
    always_comb begin
        readingOut_next = reading_next;
        lowPower_next   = settings_next[trs_pkg::BIT_LOWPOWER];
        readyOut_next   = ready_next;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            readingOut      <= trs_pkg::READING_RST;
            lowPowerRequest <= 1'b0;
            conversionReady <= 1'b0;
        end else begin
            readingOut      <= readingOut_next;
            lowPowerRequest <= lowPower_next;
            conversionReady <= readyOut_next;
        end
    end

    assign txBit = txBit_reg;
endmodule : trs_register_set

/* sim/trs_reg_monitor.sv */
// Port checker for the thermal reading register set.
// Assumes a bind onto trs_register_set.
`timescale 1ns/10ps
module trs_reg_monitor #(parameter int TEMP_W = 12) (
    input wire logic              clock,
    input wire logic              rst_n,
    input wire logic [TEMP_W-1:0] tempFixed,
    input wire logic              resultValid,
    input wire logic              dataWrite,
    input wire logic              loadShift,
    input wire logic              shiftStep,
    input wire logic              txBit,
    input wire logic [7:0]        readingOut,
    input wire logic              lowPowerRequest,
    input wire logic              conversionReady
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_rd_src;
        $changed(readingOut) |-> $past(resultValid);
    endproperty
    a_rd_src: assert property (p_rd_src)
        else $error("reading changed without valid");
    property p_rd_val;
        $changed(readingOut) |-> readingOut == tempFixed[TEMP_W-1 -: 8];
    endproperty
    a_rd_val: assert property (p_rd_val)
        else $error("reading code wrong");
    property p_lp_wr;
        $changed(lowPowerRequest) |-> $past(dataWrite);
    endproperty
    a_lp_wr: assert property (p_lp_wr)
        else $error("low power changed without write");
    property p_lp_clr;
        lowPowerRequest [*2] |-> !conversionReady;
    endproperty
    a_lp_clr: assert property (p_lp_clr)
        else $error("ready held in low power");
    property p_rdy_fall;
        $fell(conversionReady) |-> lowPowerRequest;
    endproperty
    a_rdy_fall: assert property (p_rdy_fall)
        else $error("ready fell without low power");
    property p_rdy_set;
        $rose(resultValid) && !lowPowerRequest |-> ##[1:4] conversionReady;
    endproperty
    a_rdy_set: assert property (p_rdy_set)
        else $error("ready not set after valid");
    property p_rdy_src;
        $rose(conversionReady) |-> $past(resultValid);
    endproperty
    a_rdy_src: assert property (p_rdy_src)
        else $error("ready rose without valid");
    property p_tx_hold;
        !$past(loadShift) && !$past(shiftStep) |-> $stable(txBit);
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("transmit bit moved while idle");
endmodule : trs_reg_monitor

/* sim/trs_host_model.sv */
// Host bus engine model: command, byte write and serial byte read.
// Assumes strobes are sampled on the rising clock edge.
`timescale 1ns/10ps
module trs_host_model (
    input  wire logic       clock,
    input  wire logic       txBit,
    output logic            cmdWrite = 1'b0,
    output logic      [7:0] cmdByte = 8'h00,
    output logic            dataWrite = 1'b0,
    output logic      [7:0] dataByte = 8'h00,
    output logic            loadShift = 1'b0,
    output logic            shiftStep = 1'b0
);
    task automatic cmd(input logic [7:0] c);
        @(posedge clock);
        #1 cmdWrite = 1'b1;
        cmdByte = c;
        @(posedge clock);
        #1 cmdWrite = 1'b0;
        cmdByte = ~c;
    endtask : cmd
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        cmd(c);
        dataWrite = 1'b1;
        dataByte = d;
        @(posedge clock);
        #1 dataWrite = 1'b0;
        dataByte = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] c, output logic [7:0] d);
        cmd(c);
        loadShift = 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            #1 d = {d[6:0], txBit};
            loadShift = 1'b0;
            shiftStep = (i < 7);
        end
    endtask : rd
endmodule : trs_host_model

/* sim/trs_register_set_tb.sv */
// Self-checking bench for the thermal reading register set.
// Assumes trs_host_model and trs_reg_monitor are compiled first.
`timescale 1ns/10ps
module trs_register_set_tb;
    logic        clock = 1'b0, rst_n = 1'b0, resultValid = 1'b0, txBit;
    logic [11:0] tempFixed = 12'h000;
    logic        cmdWrite, dataWrite, loadShift, shiftStep;
    logic        lowPowerRequest, conversionReady;
    logic [7:0]  cmdByte, dataByte, readingOut, v;
    logic [11:0] tin [7] = '{12'h7F0, 12'h7E8, 12'h194, 12'h008, 12'hFFC,
                             12'hE6C, 12'hBF0};
    int          fails = 0, comparisons = 0;
    always #5 clock = ~clock;
    trs_register_set #(.TEMP_W(12)) i_trs_register_set (.clock(clock),
        .rst_n(rst_n), .tempFixed(tempFixed), .resultValid(resultValid),
        .cmdWrite(cmdWrite), .cmdByte(cmdByte), .dataWrite(dataWrite),
        .dataByte(dataByte), .loadShift(loadShift), .shiftStep(shiftStep),
        .txBit(txBit), .readingOut(readingOut),
        .lowPowerRequest(lowPowerRequest), .conversionReady(conversionReady));
    trs_host_model i_trs_host_model (.clock(clock), .txBit(txBit),
        .cmdWrite(cmdWrite), .cmdByte(cmdByte), .dataWrite(dataWrite),
        .dataByte(dataByte), .loadShift(loadShift), .shiftStep(shiftStep));
    task automatic chk(input string n, input logic [7:0] s,
                       input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic close_out;
        if (fails == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out
    task automatic conv(input logic [11:0] t);
        @(posedge clock);
        #1 tempFixed = t;
        resultValid = 1'b1;
        repeat (6) @(posedge clock);
        #1 resultValid = 1'b0;
    endtask : conv
    task automatic rdc(input string n, input logic [7:0] c,
                       input logic [7:0] e);
        i_trs_host_model.rd(c, v);
        chk(n, v, e);
    endtask : rdc
    initial begin
        repeat (16) @(posedge clock);
        #1 rst_n = 1'b1;
        rdc("reading", 8'h00, 8'h00);
        rdc("settings", 8'h01, 8'h00);
        chk("conversionReady", {7'h00, conversionReady}, 8'h00);
        foreach (tin[i]) begin
            conv(tin[i]);
            rdc("reading", 8'h00, tin[i][11:4]);
            chk("readingOut", readingOut, tin[i][11:4]);
        end
        chk("conversionReady", {7'h00, conversionReady}, 8'h01);
        rdc("settings", 8'h01, 8'h40);
        i_trs_host_model.wr(8'h00, 8'h55);
        rdc("reading", 8'h00, 8'hBF);
        i_trs_host_model.wr(8'h01, 8'hFF);
        chk("lowPowerRequest", {7'h00, lowPowerRequest}, 8'h01);
        rdc("settings", 8'h01, 8'h80);
        chk("conversionReady", {7'h00, conversionReady}, 8'h00);
        conv(12'h100);
        rdc("reading", 8'h00, 8'hBF);
        i_trs_host_model.wr(8'h01, 8'h00);
        chk("lowPowerRequest", {7'h00, lowPowerRequest}, 8'h00);
        rdc("unmapped", 8'h05, 8'h00);
        rdc("settings", 8'h01, 8'h00);
        close_out();
    end
endmodule : trs_register_set_tb
bind trs_register_set trs_reg_monitor #(.TEMP_W(TEMP_W)) i_trs_reg_monitor (
    .clock(clock), .rst_n(rst_n), .tempFixed(tempFixed),
    .resultValid(resultValid), .dataWrite(dataWrite), .loadShift(loadShift),
    .shiftStep(shiftStep), .txBit(txBit), .readingOut(readingOut),
    .lowPowerRequest(lowPowerRequest), .conversionReady(conversionReady));
